// ### hw/bmbc_pkg.sv
/*
  Package for the buffered memory bridge configuration block: register map,
  field positions, reset values and encodings.
  Assumes a 32-bit AXI4-Lite register bus and 32-bit memory addresses.
*/
package bmbc_pkg;
  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] BMBC_WTO_OFF = 8'h00;
  localparam logic [7:0] BMBC_UWB_OFF = 8'h04;
  localparam logic [7:0] BMBC_UWS_OFF = 8'h08;
  localparam logic [7:0] BMBC_CFG_OFF = 8'h0C;
  localparam logic [7:0] BMBC_DEA_OFF = 8'h10;
  localparam logic [7:0] BMBC_SEA_OFF = 8'h14;
  localparam logic [7:0] BMBC_BEM_OFF = 8'h18;
  localparam logic [7:0] BMBC_BDD_OFF = 8'h1C;
  localparam logic [7:0] BMBC_EXS_OFF = 8'h20;
  localparam logic [7:0] BMBC_MSK_OFF = 8'h24;
  // ==========================================================================
  // Reset values and window size codes
  localparam logic [9:0] BMBC_WTO_RST = 10'h3FF;
  localparam logic [15:0] BMBC_UWB_RST = 16'hA000;
  localparam logic [3:0] BMBC_UWS_RST = 4'h0;
  localparam logic [3:0] BMBC_UWS_NONE = 4'hF;
  localparam logic [3:0] BMBC_UWS_MAX = 4'hE;
  localparam logic [4:0] BMBC_CFG_RST = 5'h0F;
  // ==========================================================================
  // Bridge configuration fields
  localparam int BMBC_CFG_DMA_WEN = 0;
  localparam int BMBC_CFG_DMA_REN = 1;
  localparam int BMBC_CFG_SW_WEN = 2;
  localparam int BMBC_CFG_SW_REN = 3;
  localparam int BMBC_CFG_BURST16 = 4;
  // External status bits
  localparam int BMBC_EXS_DMA_ERR = 0;
  localparam int BMBC_EXS_SW_ERR = 1;
  localparam int BMBC_EXS_FLUSH = 2;
  localparam int BMBC_EXS_W = 3;
  // Burst lengths in 32-bit words
  localparam logic [3:0] BMBC_BURST32_WORDS = 4'h8;
  localparam logic [3:0] BMBC_BURST16_WORDS = 4'h4;
  // AXI responses
  localparam logic [1:0] BMBC_RESP_OKAY = 2'h0;
  localparam logic [1:0] BMBC_RESP_SLVERR = 2'h2;
endpackage : bmbc_pkg

// ### hw/bmbc_cfg_if.sv
/*
  Configuration bundle between the register file and the window decoder.
  Assumes both ends on REF_CLK_I.
*/
`timescale 1ns/10ps
`default_nettype none
interface bmbc_cfg_if;
  logic [15:0] win_base;
  logic [3:0] win_size;
  logic [31:0] addr;
  logic unbuffered;
  modport regs (output win_base, output win_size, output addr, input unbuffered);
  modport dec (input win_base, input win_size, input addr, output unbuffered);
endinterface : bmbc_cfg_if
`default_nettype wire

// ### hw/bmbc_window.sv
/*
  Unbuffered window decoder: classes an address as inside the window.
  Assumes size codes 0..14 select 64 KB << code, code 15 means none.
*/
`timescale 1ns/10ps
`default_nettype none
module bmbc_window
  import bmbc_pkg::*;
(
  bmbc_cfg_if.dec cfg
);
  // ==========================================================================
  // Window compare
  wire [31:0] base_addr = {cfg.win_base, 16'h0000};
  wire [32:0] span = 33'h000010000 << cfg.win_size;
  wire [32:0] top_addr = {1'b0, base_addr} + span;
  wire size_ok = (cfg.win_size <= BMBC_UWS_MAX);
  // In window when base <= addr < base + size; none disables it
  assign cfg.unbuffered = size_ok && (cfg.addr >= base_addr) &&
    ({1'b0, cfg.addr} < top_addr); // [R15] [R5] [R13]
endmodule : bmbc_window
`default_nettype wire

// ### hw/bmbc_top.sv
/*
  Buffered memory bridge configuration: AXI4-Lite registers, write-combine
  timeout, unbuffered window, per-master buffer enables, burst size,
  single-to-burst conversion for the fast DMA master, status and interrupt.
  Assumes one 100 MHz clock, synchronous active-high reset, and that the
  memory side accepts one burst request at a time.
*/
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
// Overview of operation
// [R1] The write timeout start value is a 10-bit register that resets to 3FF.
// [R2] Software must load a nonzero timeout when it wants write combining.
// [R3] Window size selects 64 KB to 1 GB or none, and resets to 64 KB.
// [R4] Window base is a 16-bit upper address field resetting to A000.
// [R5] By default A0000000 up to but not including A0010000 is unbuffered.
// [R6] Each master has write and read buffer enables, set at reset, else bypass; only the DMA bits act, SW bits 2 and 3 are stored only.
// [R7] Burst length is 32 or 16 bytes.
// [R8] Buffered single transfers of the DMA master become bursts to memory.
// [R9] Read-only status shows both error addresses, buffer empty, disable done.
// [R10] The external status register clears a bit on a written one.
// [R11] The timeout loads on the first buffered write, counts down, flushes at 0.
// [R12] A write hitting the buffer tag merges into its addressed byte lanes; a hit in the cycle the timer is 0 is acknowledged but not merged.
// [R13] Accesses inside the unbuffered window bypass the buffers.
// [R14] A read hitting a pending write tag stalls until the flush completes.
// [R15] Unbuffered means base <= address < base plus size, never with none.
// [R16] Reset restores every configuration value to its default.
`timescale 1ns/10ps
`default_nettype none
module bmbc_top
  import bmbc_pkg::*;
#(
  parameter int TMR_W = 10
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // AXI4-Lite slave
  input wire logic [7:0] S_AWADDR_I,
  input wire logic S_AWVALID_I,
  output logic S_AWREADY_O,
  input wire logic [31:0] S_WDATA_I,
  input wire logic [3:0] S_WSTRB_I,
  input wire logic S_WVALID_I,
  output logic S_WREADY_O,
  output logic [1:0] S_BRESP_O,
  output logic S_BVALID_O,
  input wire logic S_BREADY_I,
  input wire logic [7:0] S_ARADDR_I,
  input wire logic S_ARVALID_I,
  output logic S_ARREADY_O,
  output logic [31:0] S_RDATA_O,
  output logic [1:0] S_RRESP_O,
  output logic S_RVALID_O,
  input wire logic S_RREADY_I,
  // Fast DMA master request side
  input wire logic DMA_REQ_I,
  input wire logic DMA_WRITE_I,
  input wire logic [31:0] DMA_ADDR_I,
  input wire logic [31:0] DMA_WDATA_I,
  input wire logic [3:0] DMA_STRB_I,
  output logic DMA_READY_O,
  input wire logic DMA_ERR_I,
  input wire logic SW_ERR_I,
  input wire logic [31:0] SW_ADDR_I,
  input wire logic SW_DISABLE_DONE_I,
  // Memory side request
  output logic MEM_REQ_O,
  output logic MEM_WRITE_O,
  output logic [31:0] MEM_ADDR_O,
  output logic [3:0] MEM_LEN_O,
  output logic [255:0] MEM_WDATA_O,
  output logic [31:0] MEM_STRB_O,
  input wire logic MEM_ACK_I,
  output logic IRQ_O
);
  // ==========================================================================
  // Configuration registers
  logic [9:0] wto_r;
  logic [15:0] uwb_r;
  logic [3:0] uws_r;
  logic [4:0] cfg_r;
  logic [BMBC_EXS_W-1:0] exs_r, msk_r;
  logic [31:0] dea_r, sea_r;
  // Write combine buffer state
  logic [31:0] tag_r;
  logic [255:0] data_r;
  logic [31:0] strb_r;
  logic valid_r;
  logic [TMR_W-1:0] tmr_r;
  logic flush_r;
  logic flush_pend_r;
  // Bus slave state
  logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] rresp_r, bresp_r;
  bmbc_cfg_if cfg_bus ();
  bmbc_window u_window (.cfg(cfg_bus.dec));
  assign cfg_bus.win_base = uwb_r;
  assign cfg_bus.win_size = uws_r;
  assign cfg_bus.addr = DMA_ADDR_I;
  // ==========================================================================
  // Register write path
  wire do_wr = aw_got_r && w_got_r && !bvalid_r;
  wire wr_known = (awaddr_r == BMBC_WTO_OFF) || (awaddr_r == BMBC_UWB_OFF) ||
    (awaddr_r == BMBC_UWS_OFF) || (awaddr_r == BMBC_CFG_OFF) ||
    (awaddr_r == BMBC_EXS_OFF) || (awaddr_r == BMBC_MSK_OFF);
  wire wr_wto = do_wr && (awaddr_r == BMBC_WTO_OFF);
  wire wr_uwb = do_wr && (awaddr_r == BMBC_UWB_OFF);
  wire wr_uws = do_wr && (awaddr_r == BMBC_UWS_OFF);
  wire wr_cfg = do_wr && (awaddr_r == BMBC_CFG_OFF);
  wire wr_exs = do_wr && (awaddr_r == BMBC_EXS_OFF);
  wire wr_msk = do_wr && (awaddr_r == BMBC_MSK_OFF);
  assign S_AWREADY_O = !aw_got_r && !bvalid_r;
  assign S_WREADY_O = !w_got_r && !bvalid_r;
  assign S_BVALID_O = bvalid_r;
  assign S_BRESP_O = bresp_r;
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      bvalid_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bresp_r <= BMBC_RESP_OKAY;
    end else begin
      if (S_AWVALID_I && S_AWREADY_O) begin
        aw_got_r <= 1'b1;
        awaddr_r <= S_AWADDR_I;
      end
      if (S_WVALID_I && S_WREADY_O) begin
        w_got_r <= 1'b1;
        wdata_r <= S_WDATA_I;
        wstrb_r <= S_WSTRB_I;
      end
      if (do_wr) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_known ? BMBC_RESP_OKAY : BMBC_RESP_SLVERR;
      end else if (bvalid_r && S_BREADY_I) begin
        bvalid_r <= 1'b0;
      end
    end
  end
  // Byte lanes enabled by the write strobes
  wire [31:0] wr_mask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire [31:0] wr_val = wdata_r & wr_mask;
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      wto_r <= BMBC_WTO_RST; // [R1] [R16]
      uwb_r <= BMBC_UWB_RST; // [R4] [R16]
      uws_r <= BMBC_UWS_RST; // [R3] [R16]
      cfg_r <= BMBC_CFG_RST; // [R6] [R7] [R16]
      msk_r <= '0;
    end else begin
      if (wr_wto && wstrb_r[0]) wto_r[7:0] <= wr_val[7:0]; // [R1]
      if (wr_wto && wstrb_r[1]) wto_r[9:8] <= wr_val[9:8];
      if (wr_uwb) uwb_r <= (uwb_r & ~wr_mask[15:0]) | wr_val[15:0]; // [R4]
      if (wr_uws && wstrb_r[0]) uws_r <= wr_val[3:0]; // [R3]
      if (wr_cfg && wstrb_r[0]) cfg_r <= wr_val[4:0]; // [R6] [R7]
      if (wr_msk && wstrb_r[0]) msk_r <= wr_val[BMBC_EXS_W-1:0];
    end
  end
  // ==========================================================================
  // Fast DMA master path and write combine buffer
  wire burst16 = cfg_r[BMBC_CFG_BURST16];
  wire [31:0] line_mask = burst16 ? 32'hFFFFFFF0 : 32'hFFFFFFE0; // [R7]
  wire [31:0] line_addr = DMA_ADDR_I & line_mask;
  wire [2:0] word_idx = burst16 ? {1'b0, DMA_ADDR_I[3:2]} : DMA_ADDR_I[4:2];
  wire bypass = cfg_bus.unbuffered; // [R13]
  wire wbuf_on = cfg_r[BMBC_CFG_DMA_WEN] && !bypass; // [R6]
  wire rbuf_on = cfg_r[BMBC_CFG_DMA_REN] && !bypass; // [R6]
  wire tag_hit = valid_r && (line_addr == tag_r);
  wire mem_busy = flush_pend_r;
  wire is_wr = DMA_REQ_I && DMA_WRITE_I;
  wire is_rd = DMA_REQ_I && !DMA_WRITE_I;
  wire rd_stall = is_rd && (tag_hit || flush_pend_r); // [R14]
  wire wr_merge = is_wr && wbuf_on && (!valid_r || tag_hit) && !mem_busy; // [R12]
  wire wr_direct = is_wr && !wbuf_on && !valid_r && !mem_busy;
  wire rd_go = is_rd && !rd_stall && !mem_busy;
  wire tmr_zero = valid_r && (tmr_r == '0);
  wire start_flush = valid_r && !flush_pend_r && (tmr_zero ||
    (is_wr && !tag_hit) || (is_rd && tag_hit));
  assign DMA_READY_O = (wr_merge || ((wr_direct || rd_go) && MEM_ACK_I));
  wire [31:0] strb_word = {28'h0000000, DMA_STRB_I} << {word_idx, 2'b00};
  wire [255:0] data_word = {224'h0, DMA_WDATA_I} << {word_idx, 5'b00000};
  wire [255:0] lane_bits;
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_lane
      assign lane_bits[g*8 +: 8] = {8{strb_word[g]}};
    end
  endgenerate
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      valid_r <= 1'b0;
      tag_r <= 32'h00000000;
      data_r <= '0;
      strb_r <= 32'h00000000;
      tmr_r <= '0;
      flush_pend_r <= 1'b0;
    end else begin
      if (start_flush) begin
        flush_pend_r <= 1'b1; // [R11]
      end else if (flush_pend_r && MEM_ACK_I) begin
        flush_pend_r <= 1'b0;
        valid_r <= 1'b0;
        strb_r <= 32'h00000000;
        data_r <= '0;
      end else if (wr_merge) begin
        if (!valid_r) begin
          valid_r <= 1'b1;
          tag_r <= line_addr;
          tmr_r <= TMR_W'(wto_r); // [R11]
        end
        data_r <= (data_r & ~lane_bits) | (data_word & lane_bits); // [R12]
        strb_r <= strb_r | strb_word; // [R12]
      end else if (valid_r && tmr_r != '0) begin
        tmr_r <= tmr_r - TMR_W'(1); // [R11]
      end
    end
  end
  // ==========================================================================
  // Memory request mux
  always_comb begin
    MEM_REQ_O = 1'b0;
    MEM_WRITE_O = 1'b0;
    MEM_ADDR_O = DMA_ADDR_I;
    MEM_LEN_O = 4'h1;
    MEM_WDATA_O = data_word;
    MEM_STRB_O = strb_word;
    if (flush_pend_r) begin
      MEM_REQ_O = 1'b1;
      MEM_WRITE_O = 1'b1;
      MEM_ADDR_O = tag_r;
      MEM_LEN_O = burst16 ? BMBC_BURST16_WORDS : BMBC_BURST32_WORDS; // [R8]
      MEM_WDATA_O = data_r;
      MEM_STRB_O = strb_r;
    end else if (wr_direct) begin
      MEM_REQ_O = 1'b1;
      MEM_WRITE_O = 1'b1;
    end else if (rd_go) begin
      MEM_REQ_O = 1'b1;
      MEM_ADDR_O = rbuf_on ? line_addr : DMA_ADDR_I;
      MEM_LEN_O = !rbuf_on ? 4'h1 : (burst16 ? BMBC_BURST16_WORDS :
        BMBC_BURST32_WORDS); // [R8]
    end
  end
  // ==========================================================================
  // Status, error capture and interrupt
  wire [BMBC_EXS_W-1:0] exs_set = {flush_pend_r && MEM_ACK_I, SW_ERR_I, DMA_ERR_I};
  wire [BMBC_EXS_W-1:0] exs_clr = wr_exs && wstrb_r[0] ? wr_val[BMBC_EXS_W-1:0] : '0;
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      exs_r <= '0;
      dea_r <= 32'h00000000;
      sea_r <= 32'h00000000;
    end else begin
      exs_r <= (exs_r & ~exs_clr) | exs_set; // [R10]
      if (DMA_ERR_I) dea_r <= DMA_ADDR_I; // [R9]
      if (SW_ERR_I) sea_r <= SW_ADDR_I; // [R9]
    end
  end
  assign IRQ_O = |(exs_r & msk_r);
  // ==========================================================================
  // Register read path
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (S_ARADDR_I)
      BMBC_WTO_OFF: rd_mux = {22'h000000, wto_r};
      BMBC_UWB_OFF: rd_mux = {16'h0000, uwb_r};
      BMBC_UWS_OFF: rd_mux = {28'h0000000, uws_r};
      BMBC_CFG_OFF: rd_mux = {27'h0000000, cfg_r};
      BMBC_DEA_OFF: rd_mux = dea_r; // [R9]
      BMBC_SEA_OFF: rd_mux = sea_r; // [R9]
      BMBC_BEM_OFF: rd_mux = {31'h00000000, !valid_r}; // [R9]
      BMBC_BDD_OFF: rd_mux = {30'h00000000, SW_DISABLE_DONE_I,
        !cfg_r[BMBC_CFG_DMA_WEN] && !valid_r}; // [R9]
      BMBC_EXS_OFF: rd_mux = {29'h00000000, exs_r};
      BMBC_MSK_OFF: rd_mux = {29'h00000000, msk_r};
      default: rd_mux = 32'h00000000;
    endcase
  end
  wire rd_known = (S_ARADDR_I[1:0] == 2'b00) && (S_ARADDR_I <= BMBC_MSK_OFF);
  assign S_ARREADY_O = !rvalid_r;
  assign S_RVALID_O = rvalid_r;
  assign S_RDATA_O = rdata_r;
  assign S_RRESP_O = rresp_r;
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= BMBC_RESP_OKAY;
    end else if (S_ARVALID_I && S_ARREADY_O) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_known ? BMBC_RESP_OKAY : BMBC_RESP_SLVERR;
    end else if (rvalid_r && S_RREADY_I) begin
      rvalid_r <= 1'b0;
    end
  end
  // ==========================================================================
  // Assertions
  a_timer_reload: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // [R11]
    wr_merge && !valid_r && !start_flush |=> tmr_r == TMR_W'(wto_r))
    else $error("timer not loaded on first write");
  a_timer_count: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // [R11]
    valid_r && !flush_pend_r && tmr_r != '0 && !start_flush && !wr_merge
    |=> tmr_r == $past(tmr_r) - TMR_W'(1))
    else $error("timer not decrementing");
  a_zero_flush: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // [R11]
    tmr_zero && !flush_pend_r |=> MEM_REQ_O && MEM_WRITE_O)
    else $error("no flush at zero");
  a_read_stall: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // [R14]
    is_rd && tag_hit |-> !DMA_READY_O)
    else $error("read passed pending write");
  a_window_bypass: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // [R13]
    is_wr && bypass |-> !wr_merge)
    else $error("window write buffered");
  a_default_window: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // [R5]
    uwb_r == BMBC_UWB_RST && uws_r == BMBC_UWS_RST |->
    cfg_bus.unbuffered == (DMA_ADDR_I[31:16] == BMBC_UWB_RST))
    else $error("default window wrong");
  a_burst_len: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // [R7] [R8]
    flush_pend_r |-> MEM_LEN_O == (burst16 ? BMBC_BURST16_WORDS : BMBC_BURST32_WORDS))
    else $error("burst length wrong");
  a_w1c_clear: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // [R10]
    wr_exs && wstrb_r[0] && wr_val[0] && !DMA_ERR_I |=> !exs_r[0])
    else $error("status not cleared");
  a_reset_defaults: assert property (@(posedge REF_CLK_I) // [R16]
    $past(RST_I) |-> wto_r == BMBC_WTO_RST && cfg_r == BMBC_CFG_RST && uwb_r == BMBC_UWB_RST)
    else $error("defaults not restored");
  c_flush: cover property (@(posedge REF_CLK_I) flush_pend_r && MEM_ACK_I);
  c_stall: cover property (@(posedge REF_CLK_I) rd_stall);
  c_bypass: cover property (@(posedge REF_CLK_I) is_wr && bypass);
endmodule : bmbc_top
`default_nettype wire

// ### tb/bmbc_mem_model.sv
/*
  Memory controller model: accepts each request after a set delay, logs it.
  Assumes the request is held until accepted.
*/
`timescale 1ns/10ps
`default_nettype none
module bmbc_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic write_i,
  input wire logic [31:0] addr_i,
  input wire logic [3:0] len_i,
  input wire logic [255:0] wdata_i,
  input wire logic [31:0] strb_i,
  input wire logic [3:0] delay_i,
  output logic ack_o
);
  // ==========================================================================
  // Acceptance and log
  logic [3:0] wait_r;
  int cnt;
  logic w_log [0:31];
  logic [31:0] a_log [0:31];
  logic [3:0] l_log [0:31];
  logic [31:0] s_log [0:31];
  logic [255:0] d_log [0:31];
  assign ack_o = req_i && (wait_r >= delay_i);
  always_ff @(posedge clk_i) begin
    if (rst_i || !req_i || ack_o) begin
      wait_r <= 4'h0;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
    if (rst_i) begin
      cnt <= 0;
    end else if (ack_o) begin
      w_log[cnt[4:0]] <= write_i;
      a_log[cnt[4:0]] <= addr_i;
      l_log[cnt[4:0]] <= len_i;
      s_log[cnt[4:0]] <= strb_i;
      d_log[cnt[4:0]] <= wdata_i;
      cnt <= cnt + 1;
    end
  end
endmodule : bmbc_mem_model
`default_nettype wire

// ### tb/bmbc_top_tb_top.sv
/*
  Testbench: AXI4-Lite register tests and fast DMA traffic.
  Assumes the package, design files and memory model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module bmbc_top_tb_top
  import bmbc_pkg::*;
;
  // ==========================================================================
  // Signals
  logic clk, rst, awv, wv, bre, arv, rre, dreq, dwr, derr, serr, sdd, mack;
  logic awr, wr, bv, arr, rv, drdy, mreq, mw, irq;
  logic [7:0] awa, ara;
  logic [31:0] wd, da, dwd, saddr, v, rd, ma, ms;
  logic [3:0] dst, dly, ml;
  logic [1:0] br, rr, r;
  logic [255:0] mwd;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int nx = 0;
  int n, i, li;
  logic [3:0] sz [0:4] = '{4'h0, 4'h0, 4'h1, 4'hF, 4'h0};
  logic [15:0] bs [0:4] = '{16'hA000, 16'hA000, 16'hA000, 16'hA000, 16'hB000};
  logic [31:0] ad [0:4] = '{32'hA001_0000, 32'hA000_FFE0, 32'hA001_0000, 32'hA000_0000,
    32'hB000_0000};
  logic [3:0] ln [0:4] = '{4'h8, 4'h1, 4'h1, 4'h8, 4'h1};
  // ==========================================================================
  // Instances
  bmbc_top dut (.REF_CLK_I(clk), .RST_I(rst), .S_AWADDR_I(awa), .S_AWVALID_I(awv),
    .S_AWREADY_O(awr), .S_WDATA_I(wd), .S_WSTRB_I(4'hF), .S_WVALID_I(wv), .S_WREADY_O(wr),
    .S_BRESP_O(br), .S_BVALID_O(bv), .S_BREADY_I(bre), .S_ARADDR_I(ara), .S_ARVALID_I(arv),
    .S_ARREADY_O(arr), .S_RDATA_O(rd), .S_RRESP_O(rr), .S_RVALID_O(rv), .S_RREADY_I(rre),
    .DMA_REQ_I(dreq), .DMA_WRITE_I(dwr), .DMA_ADDR_I(da), .DMA_WDATA_I(dwd),
    .DMA_STRB_I(dst), .DMA_READY_O(drdy), .DMA_ERR_I(derr), .SW_ERR_I(serr),
    .SW_ADDR_I(saddr), .SW_DISABLE_DONE_I(sdd), .MEM_REQ_O(mreq), .MEM_WRITE_O(mw),
    .MEM_ADDR_O(ma), .MEM_LEN_O(ml), .MEM_WDATA_O(mwd), .MEM_STRB_O(ms), .MEM_ACK_I(mack),
    .IRQ_O(irq));
  bmbc_mem_model mem (.clk_i(clk), .rst_i(rst), .req_i(mreq), .write_i(mw), .addr_i(ma),
    .len_i(ml), .wdata_i(mwd), .strb_i(ms), .delay_i(dly), .ack_o(mack));
  // ==========================================================================
  // Clock and timeout
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      finish_test;
    end
  end
  // ==========================================================================
  // Tasks
  task finish_test;
    $display("Checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_hs, w_hs, b_hs;
    @(posedge clk);
    awa <= a;
    awv <= 1'b1;
    wd <= d;
    wv <= 1'b1;
    bre <= 1'b1;
    b_hs = 1'b0;
    while (!b_hs) begin
      @(negedge clk);
      aw_hs = awv && (awr === 1'b1);
      w_hs = wv && (wr === 1'b1);
      b_hs = (bv === 1'b1);
      r = br;
      @(posedge clk);
      if (aw_hs) awv <= 1'b0;
      if (w_hs) wv <= 1'b0;
    end
    bre <= 1'b0;
  endtask : axi_wr
  task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic ar_hs, r_hs;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    r_hs = 1'b0;
    while (!r_hs) begin
      @(negedge clk);
      ar_hs = arv && (arr === 1'b1);
      r_hs = (rv === 1'b1);
      v = rd;
      r = rr;
      @(posedge clk);
      if (ar_hs) arv <= 1'b0;
    end
    rre <= 1'b0;
    check(v & m, e);
  endtask : rd_chk
  task dma(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    logic hs;
    @(posedge clk);
    dreq <= 1'b1;
    dwr <= w;
    da <= a;
    dwd <= d;
    dst <= s;
    hs = 1'b0;
    while (!hs) begin
      @(negedge clk);
      hs = (drdy === 1'b1);
      @(posedge clk);
    end
    dreq <= 1'b0;
  endtask : dma
  task mem_chk(input logic w, input logic [31:0] a, input logic [3:0] l);
    while (mem.cnt <= nx) @(negedge clk);
    li = nx % 32;
    nx = nx + 1;
    check(mem.a_log[li], a);
    check({31'h0, mem.w_log[li]}, {31'h0, w});
    check({28'h0, mem.l_log[li]}, {28'h0, l});
  endtask : mem_chk
  task pulse(input logic sw);
    @(posedge clk);
    if (sw) serr <= 1'b1;
    else derr <= 1'b1;
    @(posedge clk);
    serr <= 1'b0;
    derr <= 1'b0;
  endtask : pulse
  // ==========================================================================
  // Tests
  initial begin
    rst <= 1'b1;
    {awv, wv, bre, arv, rre, dreq, dwr, derr, serr, sdd} <= 10'h000;
    {awa, ara, wd, da, dwd, saddr, dst, dly} <= '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_chk(BMBC_WTO_OFF, 32'hFFFF_FFFF, 32'h0000_03FF);
    rd_chk(BMBC_UWB_OFF, 32'hFFFF_FFFF, 32'h0000_A000);
    rd_chk(BMBC_UWS_OFF, 32'h0000_000F, 32'h0000_0000);
    rd_chk(BMBC_CFG_OFF, 32'h0000_001F, 32'h0000_000F);
    rd_chk(BMBC_BEM_OFF, 32'h0000_0001, 32'h0000_0001);
    axi_wr(BMBC_WTO_OFF, 32'hFFFF_FFFF);
    rd_chk(BMBC_WTO_OFF, 32'hFFFF_FFFF, 32'h0000_03FF);
    axi_wr(BMBC_UWB_OFF, 32'h0000_0000);
    rd_chk(BMBC_UWB_OFF, 32'hFFFF_FFFF, 32'h0000_0000);
    axi_wr(BMBC_UWB_OFF, 32'h0000_A000);
    axi_wr(BMBC_DEA_OFF, 32'hFFFF_FFFF);
    rd_chk(BMBC_DEA_OFF, 32'hFFFF_FFFF, 32'h0000_0000);
    axi_wr(8'h40, 32'h0000_0000);
    check({30'h0, r}, {30'h0, BMBC_RESP_SLVERR});
    rd_chk(BMBC_CFG_OFF, 32'h0000_001F, 32'h0000_000F);
    $display("Test registers done");
    axi_wr(BMBC_WTO_OFF, 32'h0000_0014);
    dma(1'b1, 32'h1000_0004, 32'h1111_2222, 4'hF);
    n = 0;
    while (mreq !== 1'b1 && n < 100) begin
      @(negedge clk);
      n = n + 1;
    end
    check({31'h0, (n >= 20 && n <= 23)}, 32'h1);
    mem_chk(1'b1, 32'h1000_0000, BMBC_BURST32_WORDS);
    check(mem.s_log[li], 32'h0000_00F0);
    check(mem.d_log[li][63:32], 32'h1111_2222);
    $display("Test timeout done");
    axi_wr(BMBC_WTO_OFF, 32'h0000_03FF);
    @(posedge clk);
    dly <= 4'h3;
    dma(1'b1, 32'h1000_0104, 32'hAAAA_BBBB, 4'hF);
    dma(1'b1, 32'h1000_0108, 32'hCCCC_DDDD, 4'h3);
    rd_chk(BMBC_BEM_OFF, 32'h0000_0001, 32'h0000_0000);
    dma(1'b0, 32'h1000_0100, 32'h0, 4'hF);
    mem_chk(1'b1, 32'h1000_0100, BMBC_BURST32_WORDS);
    check(mem.s_log[li], 32'h0000_03F0);
    check(mem.d_log[li][95:64] & 32'h0000_FFFF, 32'h0000_DDDD);
    mem_chk(1'b0, 32'h1000_0100, BMBC_BURST32_WORDS);
    rd_chk(BMBC_BEM_OFF, 32'h0000_0001, 32'h0000_0001);
    rd_chk(BMBC_EXS_OFF, 32'h0000_0004, 32'h0000_0004);
    axi_wr(BMBC_CFG_OFF, 32'h0000_001F);
    dma(1'b0, 32'h2000_0014, 32'h0, 4'hF);
    mem_chk(1'b0, 32'h2000_0010, BMBC_BURST16_WORDS);
    axi_wr(BMBC_CFG_OFF, 32'h0000_000F);
    $display("Test combining done");
    dma(1'b1, 32'hA000_0040, 32'h5, 4'hF);
    mem_chk(1'b1, 32'hA000_0040, 4'h1);
    for (i = 0; i < 5; i++) begin
      axi_wr(BMBC_UWS_OFF, {28'h0, sz[i]});
      axi_wr(BMBC_UWB_OFF, {16'h0, bs[i]});
      dma(1'b0, ad[i], 32'h0, 4'hF);
      mem_chk(1'b0, ad[i], ln[i]);
    end
    axi_wr(BMBC_CFG_OFF, 32'h0000_000E);
    dma(1'b1, 32'h3000_0000, 32'h1, 4'hF);
    mem_chk(1'b1, 32'h3000_0000, 4'h1);
    axi_wr(BMBC_CFG_OFF, 32'h0000_000D);
    dma(1'b0, 32'h3000_0020, 32'h0, 4'hF);
    mem_chk(1'b0, 32'h3000_0020, 4'h1);
    $display("Test window done");
    axi_wr(BMBC_MSK_OFF, 32'h0000_0001);
    axi_wr(BMBC_EXS_OFF, 32'h0000_0007);
    @(negedge clk);
    check({31'h0, irq}, 32'h0);
    pulse(1'b0);
    axi_wr(BMBC_EXS_OFF, 32'h0000_0000);
    rd_chk(BMBC_EXS_OFF, 32'h0000_0007, 32'h0000_0001);
    rd_chk(BMBC_DEA_OFF, 32'hFFFF_FFFF, 32'h3000_0020);
    @(negedge clk);
    check({31'h0, irq}, 32'h1);
    axi_wr(BMBC_EXS_OFF, 32'h0000_0001);
    rd_chk(BMBC_EXS_OFF, 32'h0000_0007, 32'h0000_0000);
    @(negedge clk);
    check({31'h0, irq}, 32'h0);
    saddr <= 32'h5555_0000;
    pulse(1'b1);
    rd_chk(BMBC_SEA_OFF, 32'hFFFF_FFFF, 32'h5555_0000);
    @(negedge clk);
    check({31'h0, irq}, 32'h0);
    sdd <= 1'b1;
    rd_chk(BMBC_BDD_OFF, 32'h0000_0002, 32'h0000_0002);
    $display("Test status done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_chk(BMBC_CFG_OFF, 32'h0000_001F, 32'h0000_000F);
    rd_chk(BMBC_UWB_OFF, 32'hFFFF_FFFF, 32'h0000_A000);
    rd_chk(BMBC_EXS_OFF, 32'h0000_0007, 32'h0000_0000);
    $display("Test reset done");
    finish_test;
  end
endmodule : bmbc_top_tb_top
`default_nettype wire
